// >>> core/gpc_port.sv
// eight-bit bidirectional port with change interrupt, axi4-lite slave
// Notes on behaviour
// R1: there are eight pins, each with a data bit and a direction bit.
// R2: a direction bit of 1 makes the pin an input, 0 drives the latch out.
// R3: reading the data register gives pin levels; writes go to the latch.
// R4: clearing the active-low bit 7 of the companion register enables pulls.
// R5: a pin set as output never has its weak pull-up on.
// R6: pull-ups are enabled after every reset.
// R7: output pins are left out of the change comparison.
// R8: input pins mismatching the latch are ORed into flag bit 7.
// R9: an asserted change interrupt wakes the device from halt.
// R10: the flag keeps setting while any input mismatch remains.
// R11: software reads and writes back the port before clearing the flag.
// R12: change wake-up is best used when the port serves only that purpose.
// R13: pin levels are synchronised before the change comparison.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gpc_defines.svh"
module gpc_port #(
    parameter int PINS = 8
) (
    input  wire logic            clock_i,
    input  wire logic            reset_n_i,
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    input  wire logic [PINS-1:0] port_pin_bits_i,
    output logic      [PINS-1:0] port_pin_bits_o,
    output logic      [PINS-1:0] port_pin_bits_oe_o,
    output logic      [PINS-1:0] pullup_en_o,
    input  wire logic            halted_i,
    output logic                 wake_o,
    output logic                 irq_o
);
    logic [PINS-1:0]      pins_sync;
    logic [PINS-1:0]      latch_r;
    logic [PINS-1:0]      latch_nxt;
    logic [PINS-1:0]      dir_r;
    logic [PINS-1:0]      dir_nxt;
    logic [7:0]           comp_r;
    logic [7:0]           comp_nxt;
    logic                 flag_r;
    logic                 flag_nxt;
    logic                 mask_r;
    logic                 mask_nxt;
    logic [PINS-1:0]      mismatch;
    logic                 change;

    gpc_pkg::gpc_wstate_e wst_r;
    gpc_pkg::gpc_wstate_e wst_nxt;
    logic                 aw_have_r;
    logic                 aw_have_nxt;
    logic                 w_have_r;
    logic                 w_have_nxt;
    logic [7:0]           awaddr_r;
    logic [7:0]           awaddr_nxt;
    logic [31:0]          wdata_r;
    logic [31:0]          wdata_nxt;
    logic                 wstrb0_r;
    logic                 wstrb0_nxt;
    logic [1:0]           bresp_r;
    logic [1:0]           bresp_nxt;
    logic                 rvalid_r;
    logic                 rvalid_nxt;
    logic [31:0]          rdata_r;
    logic [31:0]          rdata_nxt;
    logic [1:0]           rresp_r;
    logic [1:0]           rresp_nxt;

    // pin levels are asynchronous to the core clock
    gpc_sync #(.WIDTH(PINS)) u_sync ( // R13
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   (port_pin_bits_i),
        .sync_o    (pins_sync)
    );

    assign port_pin_bits_o    = latch_r;          // R1
    assign port_pin_bits_oe_o = ~dir_r;           // R2
    // pulls only on inputs, all gated by the shared low-active bit
    assign pullup_en_o = dir_r &
        {PINS{~comp_r[`GPC_PULLUP_BIT]}};         // R4 R5
    assign mismatch = dir_r & (pins_sync ^ latch_r); // R7
    assign change   = |mismatch;                  // R8
    assign irq_o    = flag_r & mask_r;
    assign wake_o   = halted_i & irq_o;           // R9

    assign s_axi_awready = (wst_r == gpc_pkg::GPC_W_IDLE) && !aw_have_r;
    assign s_axi_wready  = (wst_r == gpc_pkg::GPC_W_IDLE) && !w_have_r;
    assign s_axi_bvalid  = (wst_r == gpc_pkg::GPC_W_RESP);
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // write channel: address and data in either order
    always_comb begin
        wst_nxt     = wst_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb0_nxt  = wstrb0_r;
        bresp_nxt   = bresp_r;
        unique case (wst_r)
            gpc_pkg::GPC_W_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_have_nxt = 1'h1;
                    awaddr_nxt  = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_have_nxt = 1'h1;
                    wdata_nxt  = s_axi_wdata;
                    wstrb0_nxt = s_axi_wstrb[0];
                end
                if (aw_have_nxt && w_have_nxt) begin
                    wst_nxt = gpc_pkg::GPC_W_EXEC;
                end
            end
            gpc_pkg::GPC_W_EXEC: begin
                unique case (awaddr_r)
                    `GPC_OFS_DATA, `GPC_OFS_DIR, `GPC_OFS_COMPANION,
                    `GPC_OFS_IRQ_FLAGS, `GPC_OFS_IRQ_MASK:
                        bresp_nxt = `GPC_RESP_OKAY;
                    default: bresp_nxt = `GPC_RESP_SLVERR;
                endcase
                wst_nxt = gpc_pkg::GPC_W_RESP;
            end
            gpc_pkg::GPC_W_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt     = gpc_pkg::GPC_W_IDLE;
                    aw_have_nxt = 1'h0;
                    w_have_nxt  = 1'h0;
                end
            end
        endcase
    end

    // register file; writes commit in the exec state
    always_comb begin
        logic wr;
        wr        = (wst_r == gpc_pkg::GPC_W_EXEC) && wstrb0_r;
        latch_nxt = latch_r;
        dir_nxt   = dir_r;
        comp_nxt  = comp_r;
        mask_nxt  = mask_r;
        flag_nxt  = flag_r;
        if (wr) begin
            unique case (awaddr_r)
                `GPC_OFS_DATA:      latch_nxt = wdata_r[PINS-1:0]; // R3
                `GPC_OFS_DIR:       dir_nxt   = wdata_r[PINS-1:0]; // R2
                `GPC_OFS_COMPANION: comp_nxt  = wdata_r[7:0];      // R4
                `GPC_OFS_IRQ_MASK:  mask_nxt  = wdata_r[`GPC_CHANGE_BIT];
                `GPC_OFS_IRQ_FLAGS: begin
                    if (wdata_r[`GPC_CHANGE_BIT]) begin
                        flag_nxt = 1'h0;
                    end
                end
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        if (change) begin
            flag_nxt = 1'h1;                      // R10
        end
    end

    // read channel: one cycle from address to data
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'h0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'h1;
            rdata_nxt  = 32'h0000_0000;
            rresp_nxt  = `GPC_RESP_OKAY;
            unique case (s_axi_araddr)
                `GPC_OFS_DATA:      rdata_nxt[PINS-1:0] = pins_sync; // R3
                `GPC_OFS_DIR:       rdata_nxt[PINS-1:0] = dir_r;
                `GPC_OFS_COMPANION: rdata_nxt[7:0]      = comp_r;
                `GPC_OFS_IRQ_FLAGS: rdata_nxt[`GPC_CHANGE_BIT] = flag_r; // R8
                `GPC_OFS_IRQ_MASK:  rdata_nxt[`GPC_CHANGE_BIT] = mask_r;
                default:            rresp_nxt = `GPC_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            latch_r   <= `GPC_DATA_RESET;
            dir_r     <= `GPC_DIR_RESET;
            comp_r    <= `GPC_COMP_RESET;         // R6
            flag_r    <= 1'h0;
            mask_r    <= 1'h0;
            wst_r     <= gpc_pkg::GPC_W_IDLE;
            aw_have_r <= 1'h0;
            w_have_r  <= 1'h0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb0_r  <= 1'h0;
            bresp_r   <= `GPC_RESP_OKAY;
            rvalid_r  <= 1'h0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `GPC_RESP_OKAY;
        end else begin
            latch_r   <= latch_nxt;
            dir_r     <= dir_nxt;
            comp_r    <= comp_nxt;
            flag_r    <= flag_nxt;
            mask_r    <= mask_nxt;
            wst_r     <= wst_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb0_r  <= wstrb0_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end
endmodule : gpc_port

// >>> common/gpc_defines.svh
// register offsets, field positions, reset values and response codes
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH
`define GPC_OFS_DATA      8'h00
`define GPC_OFS_DIR       8'h04
`define GPC_OFS_COMPANION 8'h08
`define GPC_OFS_IRQ_FLAGS 8'h0C
`define GPC_OFS_IRQ_MASK  8'h10
`define GPC_PULLUP_BIT    7
`define GPC_CHANGE_BIT    7
`define GPC_DIR_RESET     8'hFF
`define GPC_DATA_RESET    8'h00
`define GPC_COMP_RESET    8'h00
`define GPC_MASK_RESET    8'h00
`define GPC_RESP_OKAY     2'h0
`define GPC_RESP_SLVERR   2'h2
`endif

// >>> common/gpc_pkg.sv
// types shared by the port block
package gpc_pkg;
    typedef logic [7:0] gpc_byte_t;
    typedef enum logic [2:0] {
        GPC_W_IDLE = 3'h1,
        GPC_W_EXEC = 3'h2,
        GPC_W_RESP = 3'h4
    } gpc_wstate_e;
endpackage : gpc_pkg

// >>> core/gpc_sync.sv
// two-flop synchroniser for the port pin levels
`timescale 1ns/1ps
module gpc_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;
endmodule : gpc_sync

// >>> tb/gpc_port_sva.sv
// assertions on the port block ports
`timescale 1ns/1ps
module gpc_port_sva #(
    parameter int PINS = 8
) (
    input logic            clock_i,
    input logic            reset_n_i,
    input logic            s_axi_awvalid,
    input logic            s_axi_awready,
    input logic            s_axi_wvalid,
    input logic            s_axi_wready,
    input logic            s_axi_bvalid,
    input logic            s_axi_arvalid,
    input logic            s_axi_arready,
    input logic            s_axi_rvalid,
    input logic            s_axi_rready,
    input logic [PINS-1:0] port_pin_bits_oe_o,
    input logic [PINS-1:0] pullup_en_o,
    input logic            halted_i,
    input logic            wake_o,
    input logic            irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // reset must be visible while it is held, so no disable here
    reset_pull_a: assert property (disable iff (1'h0) !reset_n_i |=>
        &pullup_en_o && !port_pin_bits_oe_o) else $error("bad reset");
    pull_out_a: assert property (!(pullup_en_o & port_pin_bits_oe_o))
        else $error("pull-up on output");
    wake_irq_a: assert property (wake_o == (halted_i && irq_o))
        else $error("wake mismatch");
    wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("late write response");
    rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("late read data");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid) else $error("read data dropped");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
    wr_block_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write overlap");
endmodule : gpc_port_sva

bind gpc_port gpc_port_sva #(.PINS(PINS)) u_gpc_port_sva (.*);

// >>> tb/gpc_keypad.sv
// keypad model on the port pins
`timescale 1ns/1ps
module gpc_keypad (
    input  logic       clock_i,
    input  logic [7:0] drv_i,
    input  logic [7:0] oe_i,
    input  logic [7:0] pull_i,
    input  logic [7:0] key_i,
    output logic [7:0] pin_o
);
    logic [7:0] flt_r = 8'h00;
    // a pin nobody drives or pulls flips each cycle: no stale level
    always @(posedge clock_i) flt_r <= ~pin_o;
    assign pin_o = oe_i & drv_i | ~oe_i & ~key_i & (pull_i | flt_r);
endmodule : gpc_keypad

// >>> tb/bidir_port_with_change_irq_tb.sv
// bench for the port block
`timescale 1ns/1ps
module bidir_port_with_change_irq_tb;
    logic clock_i = 1'h0, reset_n_i = 1'h0, halted_i = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic wake_o, irq_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, wq[$];
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, key = 8'h00;
    logic [7:0] port_pin_bits_i, port_pin_bits_o, port_pin_bits_oe_o;
    logic [7:0] pullup_en_o, d, v;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [33:0] rq[$], e;
    int num_errors = 0, n_checks = 0;

    always #4 clock_i = ~clock_i;
    gpc_port #(.PINS(8)) u_gpc_port (.*);
    gpc_keypad u_gpc_keypad (.clock_i(clock_i), .drv_i(port_pin_bits_o),
        .oe_i(port_pin_bits_oe_o), .pull_i(pullup_en_o), .key_i(key),
        .pin_o(port_pin_bits_i));

    task automatic chk(input logic c);
        n_checks++;
        if (c !== 1'h1) begin
            num_errors++;
            $display("BAD %0t mismatch", $time);
        end
    endtask : chk

    task automatic print_verdict();
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // one transfer; rready comes a cycle late so rvalid must stand
    task automatic bus(input logic w, input logic [7:0] a, x,
        input logic [1:0] r = 2'h0);
        logic ka, kw, kb;
        if (w) wq.push_back(r);
        else rq.push_back({r, 24'h0, x});
        @(posedge clock_i);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, x};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        s_axi_arvalid <= !w;
        do begin
            @(negedge clock_i);
            ka = w ? s_axi_awready : s_axi_arready;
            kw = s_axi_wready;
            kb = w ? s_axi_bvalid : s_axi_rvalid;
            @(posedge clock_i);
            if (ka) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (kw) s_axi_wvalid <= 1'h0;
            if (kb && !w) s_axi_rready <= !s_axi_rready;
        end while (!(kb && (w || s_axi_rready)));
        s_axi_bready <= 1'h0;
    endtask : bus

    always @(negedge clock_i) begin
        if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp === wq.pop_front());
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            chk(s_axi_rresp === e[33:32] && (|e[33:32] ||
                s_axi_rdata === e[31:0]));
        end
    end

    initial begin
        repeat (5000) @(posedge clock_i);
        num_errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(54103));
        repeat (8) @(posedge clock_i);
        reset_n_i <= 1'h1;
        @(negedge clock_i);
        chk(pullup_en_o === 8'hFF);
        bus(1'h0, 8'h04, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            {d, v} = 16'($urandom);
            bus(1'h1, 8'h04, d);
            bus(1'h1, 8'h00, v);
            repeat (2) @(negedge clock_i);
            chk(pullup_en_o === d && port_pin_bits_oe_o === ~d);
            chk(port_pin_bits_o === v);
            bus(1'h0, 8'h00, v & ~d | d);
        end
        bus(1'h1, 8'h08, 8'h80);
        chk(pullup_en_o === 8'h00);
        // a reset in mid-run must bring the pull-ups back
        reset_n_i <= 1'h0;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'h1;
        @(negedge clock_i);
        chk(pullup_en_o === 8'hFF && port_pin_bits_oe_o === 8'h00);
        bus(1'h1, 8'h08, 8'h00);
        bus(1'h1, 8'h04, 8'hFF);
        bus(1'h1, 8'h00, 8'hFF);
        bus(1'h1, 8'h0C, 8'h80);
        bus(1'h1, 8'h10, 8'h80);
        key <= 8'h08;
        halted_i <= 1'h1;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        chk(irq_o === 1'h1 && wake_o === 1'h1);
        @(posedge clock_i);
        halted_i <= 1'h0;
        @(negedge clock_i);
        chk(irq_o === 1'h1 && wake_o === 1'h0);
        bus(1'h1, 8'h0C, 8'h80);
        bus(1'h0, 8'h0C, 8'h80);
        bus(1'h0, 8'h00, 8'hF7);
        bus(1'h1, 8'h00, 8'hF7);
        bus(1'h1, 8'h0C, 8'h80);
        chk(irq_o === 1'h0 && wake_o === 1'h0);
        bus(1'h1, 8'h14, 8'h55, 2'h2);
        bus(1'h0, 8'h14, 8'h00, 2'h2);
        // a write with the low byte lane off leaves the register alone
        s_axi_wstrb <= 4'hE;
        bus(1'h1, 8'h04, 8'h00);
        s_axi_wstrb <= 4'hF;
        bus(1'h0, 8'h04, 8'hFF);
        print_verdict();
    end
endmodule : bidir_port_with_change_irq_tb
